// >>> tb_top.sv
// self-checking bench for the transceiver controller
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic [3:0] address = 4'h0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic [31:0] q;
    logic waitrequest;
    logic vbus = 1'b0;
    logic hostDp = 1'b1;
    logic hostDm = 1'b0;
    logic dp;
    logic dm;
    uft_pkg::uft_pin_in_s pinIn;
    uft_pkg::uft_pin_out_s pinOut;
    int failures = 0;
    int comparisons = 0;
    always #12.5 clk = ~clk;
    uft_host_ctrl u_dut (.clk(clk), .rst(rst), .ce(ce), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .pinIn(pinIn), .pinOut(pinOut));
    uft_xcvr_model u_xcvr (.pinOut(pinOut), .vbus(vbus), .hostDp(hostDp), .hostDm(hostDm),
        .pinIn(pinIn), .dp(dp), .dm(dm));
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        read <= !wr;
        write <= wr;
        address <= a;
        writedata <= d;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 100);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        check("bus answer", waitrequest, 0);
    endtask
    task automatic wait_oe(input logic v);
        for (int n = 0; n < 50 && pinOut.oeN !== v; n++) @(posedge clk);
        check("direction", pinOut.oeN, v);
    endtask
    task automatic test_reset();
        check("pins", pinOut, uft_pkg::UFT_PINS_RST);
        bus(0, 4'h2, 0);
        check("unmapped", q, 0);
        bus(0, uft_pkg::UFT_TXSYM_OFS, 0);
        check("symbol read", q, 0);
        $display("test_reset done");
    endtask
    task automatic test_ctrl();
        bus(1, uft_pkg::UFT_CTRL_OFS, 32'h3);
        @(negedge clk);
        check("suspend", pinOut.lowPowerRequest, 1);
        check("attach", pinOut.pullupConnect, 1);
        bus(1, uft_pkg::UFT_CTRL_OFS, 32'h0);
        @(negedge clk);
        check("normal", pinOut.lowPowerRequest, 0);
        check("detach", pinOut.pullupConnect, 0);
        $display("test_ctrl done");
    endtask
    task automatic test_tx();
        vbus <= 1'b1;
        repeat (10) @(posedge clk);
        // second pass sends while suspended, as for remote wake-up
        for (int s = 0; s < 2; s++) begin
            bus(1, uft_pkg::UFT_CTRL_OFS, 32'h4 | s);
            for (int i = 0; i < 3; i++) begin
                bus(1, uft_pkg::UFT_TXSYM_OFS, 32'(i));
                wait_oe(0);
                @(negedge clk);
                check("lines", {dp, dm}, i[1] ? 2'b00 : {i[0], !i[0]});
                wait_oe(1);
            end
        end
        $display("test_tx done");
    endtask
    task automatic test_rx();
        // host dp, host dm, suspend, expected valid, se0, dat
        logic [5:0] tbl [4] = '{6'b100_101, 6'b010_100, 6'b000_110, 6'b001_010};
        for (int i = 0; i < 4; i++) begin
            bus(1, uft_pkg::UFT_CTRL_OFS, {31'h0, tbl[i][3]});
            hostDp <= tbl[i][5];
            hostDm <= tbl[i][4];
            repeat (12) @(posedge clk);
            bus(0, uft_pkg::UFT_RXLINE_OFS, 0);
            check("rx line", q[2:0] & (tbl[i][3] ? 3'h6 : 3'h7), tbl[i][2:0]);
        end
        $display("test_rx done");
    endtask
    task automatic test_power();
        vbus <= 1'b0;
        repeat (10) @(posedge clk);
        bus(0, uft_pkg::UFT_STATUS_OFS, 0);
        check("power lost", q[0], 0);
        check("released", q[4], 1);
        vbus <= 1'b1;
        repeat (10) @(posedge clk);
        bus(0, uft_pkg::UFT_STATUS_OFS, 0);
        check("power back", q[0], 1);
        $display("test_power done");
    endtask
    task automatic test_hold();
        // a symbol queued without permission waits; the pins stay with the transceiver
        bus(1, uft_pkg::UFT_CTRL_OFS, 32'h0);
        bus(1, uft_pkg::UFT_TXSYM_OFS, 32'h1);
        repeat (12) @(posedge clk);
        bus(0, uft_pkg::UFT_STATUS_OFS, 0);
        check("hold full", q[2], 1);
        check("busy", q[1], 1);
        check("held back", q[4], 1);
        bus(1, uft_pkg::UFT_CTRL_OFS, 32'h4);
        wait_oe(0);
        wait_oe(1);
        bus(0, uft_pkg::UFT_CTRL_OFS, 0);
        check("symbols sent", q[31:16], 1);
        $display("test_hold done");
    endtask
    task automatic test_freeze();
        logic [15:0] c;
        bus(0, uft_pkg::UFT_RXLINE_OFS, 0);
        c = q[31:16];
        ce <= 1'b0;
        repeat (20) @(posedge clk);
        ce <= 1'b1;
        bus(0, uft_pkg::UFT_RXLINE_OFS, 0);
        check("frozen samples", (q[31:16] - c) <= 16'h0003, 1);
        $display("test_freeze done");
    endtask
    task automatic finish_test();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        test_reset();
        test_ctrl();
        test_tx();
        test_rx();
        test_power();
        test_hold();
        test_freeze();
        finish_test();
    end
    initial begin
        #200us;
        failures++;
        finish_test();
    end
endmodule // tb_top

// >>> uft_host_ctrl.sv
// controller driving a three-wire full-speed usb transceiver, with an avalon-mm slave
// Contract
// [R1] direction low and se0 high: transceiver drives both usb lines low.
// [R2] transmitting, se0 0 and dat 1: positive line high, negative low.
// [R3] transmitting, se0 0 and dat 0: positive line low, negative high.
// [R4] direction high: dat pin carries differential receiver result as output.
// [R5] receiving: se0 output high only while both usb lines are low.
// [R6] receiving: dat holds last value during se0, undefined with both lines high.
// [R7] bus-power detect high while usb supply and logic supply present.
// [R8] bus-power detect low and sharing mode when usb supply drops too low.
// [R9] direction low makes dat/se0 inputs; the controller selects direction.
// [R10] direction high makes dat/se0 outputs toward controller, usb lines inputs.
// [R11] controller holds low-power request low normally, high for suspend.
// [R12] in suspend single-ended receivers stay active for wake-up detection.
// [R13] transceiver still transmits in suspend, allowing remote wake-up.
// [R14] controller drives pull-up connect high to attach, low to detach.
// [R15] with low-power request high the differential receiver is off.
// [R16] sharing or disable mode: dat/se0 high impedance, bus-power detect low.
// [R17] controller paces symbols and samples lines at full-speed bit rate.
module uft_host_ctrl #(
    parameter int SYNC_STAGES = 3,
    parameter int COUNT_W = 16
) (
    input wire logic clk,                          // 40 MHz clock
    input wire logic rst,                          // synchronous reset, active high
    input wire logic ce,                           // clock enable, low freezes all state
    input wire logic [3:0] address,                // avalon byte address
    input wire logic read,                         // avalon read request
    input wire logic write,                        // avalon write request
    input wire logic [31:0] writedata,             // avalon write data
    output logic [31:0] readdata,                  // avalon read data
    output logic waitrequest,                      // avalon wait, low completes request
    input wire uft_pkg::uft_pin_in_s pinIn,        // levels from the transceiver pins
    output uft_pkg::uft_pin_out_s pinOut           // drives toward the transceiver pins
);

    // elaboration checks: the logic is built for these values only
    if (SYNC_STAGES != 3) begin : g_bad_sync
        $error("uft_host_ctrl: only three synchroniser stages are built");
    end
    if (COUNT_W != 16) begin : g_bad_count
        $error("uft_host_ctrl: counters are fixed at 16 bits");
    end
    // the accumulator wraps at most once per cycle only while step < modulus
    if (uft_pkg::UFT_PHASE_STEP >= uft_pkg::UFT_PHASE_MOD) begin : g_bad_phase
        $error("uft_host_ctrl: bit rate must be below the clock rate");
    end

    uft_pkg::uft_state_s r;
    uft_pkg::uft_state_s n;
    logic req;
    logic tick;
    logic [3:0] phaseSum;
    logic accept;
    logic busPower;
    logic txGo;
    logic rxGo;

    // one decode shared by read mux and write actions
    function automatic logic hitReg(input logic [3:0] addr, input logic [3:0] ofs);
        hitReg = (addr == ofs);
    endfunction

    // hand dat/se0 back to the transceiver; used on idle ticks and on power loss
    function automatic uft_pkg::uft_pin_out_s releasePins(input uft_pkg::uft_pin_out_s p);
        releasePins = p;
        releasePins.oeN = 1'b1; // see [R10]
        releasePins.datOe = 1'b0;
        releasePins.se0Oe = 1'b0;
    endfunction

    // read word of one register; unmapped and write-only offsets read as zero
    function automatic logic [31:0] readWord(input logic [3:0] addr,
            input uft_pkg::uft_state_s s, input logic power);
        readWord = uft_pkg::UFT_RDATA_RST;
        if (hitReg(addr, uft_pkg::UFT_CTRL_OFS)) begin
            readWord[uft_pkg::UFT_CTRL_LPR_BIT] = s.pins.lowPowerRequest;
            readWord[uft_pkg::UFT_CTRL_CONN_BIT] = s.pins.pullupConnect;
            readWord[uft_pkg::UFT_CTRL_TXEN_BIT] = s.txEnable;
            readWord[31:16] = s.txCount;
        end else if (hitReg(addr, uft_pkg::UFT_STATUS_OFS)) begin
            readWord[uft_pkg::UFT_ST_BPD_BIT] = power; // see [R7]
            readWord[uft_pkg::UFT_ST_BUSY_BIT] = s.holdValid | s.txActive;
            readWord[uft_pkg::UFT_ST_FULL_BIT] = s.holdValid;
            readWord[uft_pkg::UFT_ST_RXOK_BIT] = s.rxValid;
            readWord[uft_pkg::UFT_ST_DIR_BIT] = s.pins.oeN;
        end else if (hitReg(addr, uft_pkg::UFT_RXLINE_OFS)) begin
            readWord[1:0] = s.rxSym;
            readWord[uft_pkg::UFT_RX_VALID_BIT] = s.rxValid;
            readWord[31:16] = s.rxCount;
        end
    endfunction

    assign req = read | write;
    assign busPower = r.filt[2];
    assign phaseSum = r.phase + uft_pkg::UFT_PHASE_STEP;
    assign tick = (phaseSum >= uft_pkg::UFT_PHASE_MOD);
    // a symbol goes out only with one queued, permission given and bus power seen
    assign txGo = tick && r.holdValid && r.txEnable && busPower;
    // sample the lines only while the transceiver owns dat/se0
    assign rxGo = tick && r.pins.oeN;
    // a symbol write stalls on waitrequest while the hold slot is taken
    assign accept = !(write && hitReg(address, uft_pkg::UFT_TXSYM_OFS) && r.holdValid);

    always_comb begin
        n = r;

        // pin inputs: three stages, a change counts once stage two and three agree
        n.sync1 = {pinIn.busPowerDetect, pinIn.se0In, pinIn.datIn};
        n.sync2 = r.sync1;
        n.sync3 = r.sync2;
        for (int i = 0; i < 3; i++) begin
            if (r.sync2[i] == r.sync3[i]) begin
                n.filt[i] = r.sync3[i];
            end
        end

        // fractional bit clock, 3 ticks every 10 cycles; ticks fall 3, 3 or 4
        // cycles apart, so single bits jitter by one clock around the mean rate
        n.phase = tick ? (phaseSum - uft_pkg::UFT_PHASE_MOD) : phaseSum;

        if (txGo) begin // see [R17]
            // data and enable change in one cycle, so the pin sees one
            // coherent change per bit
            n.pins.oeN = 1'b0; // see [R9]
            n.pins.datOut = r.holdSym[uft_pkg::UFT_SYM_DAT_BIT]; // see [R2] [R3]
            n.pins.se0Out = r.holdSym[uft_pkg::UFT_SYM_SE0_BIT]; // see [R1]
            n.pins.datOe = 1'b1;
            n.pins.se0Oe = 1'b1;
            n.holdValid = 1'b0;
            n.txActive = 1'b1;
            n.txCount = r.txCount + 16'h0001;
        end else if (tick) begin
            // no symbol sent on this tick: hand the pins back to the transceiver
            n.pins = releasePins(r.pins);
            n.txActive = 1'b0;
        end

        if (rxGo) begin // see [R17]
            // se0 from the single-ended receivers is good even in suspend;
            // dat is only meaningful with the differential receiver on
            n.rxSym[uft_pkg::UFT_SYM_SE0_BIT] = r.filt[1]; // see [R5] [R12]
            n.rxSym[uft_pkg::UFT_SYM_DAT_BIT] = r.filt[0]; // see [R4] [R6]
            n.rxValid = !r.pins.lowPowerRequest; // see [R15]
            n.rxCount = r.rxCount + 16'h0001;
        end

        // lost usb supply: transceiver floats its side, so stop driving and drop the queue
        if (!busPower) begin // see [R8] [R16]
            n.holdValid = 1'b0;
            n.pins = releasePins(n.pins);
            n.txActive = 1'b0;
        end

        // avalon slave: take the request, answer with waitrequest low one cycle
        // later; a write lands on the edge at which the master sees that answer,
        // so no state moves before the transfer is complete
        if (!r.waitrequest) begin
            n.waitrequest = 1'b1;
            if (write) begin
                if (hitReg(address, uft_pkg::UFT_CTRL_OFS)) begin
                    // suspend does not block transmit, so wake-up can still go out
                    n.pins.lowPowerRequest = writedata[uft_pkg::UFT_CTRL_LPR_BIT]; // see [R11] [R13]
                    n.pins.pullupConnect = writedata[uft_pkg::UFT_CTRL_CONN_BIT]; // see [R14]
                    n.txEnable = writedata[uft_pkg::UFT_CTRL_TXEN_BIT];
                    n.txCount = uft_pkg::UFT_CNT_RST;
                end else if (hitReg(address, uft_pkg::UFT_TXSYM_OFS)) begin
                    n.holdSym = writedata[1:0];
                    n.holdValid = 1'b1;
                end else if (hitReg(address, uft_pkg::UFT_RXLINE_OFS)) begin
                    n.rxCount = uft_pkg::UFT_CNT_RST;
                end
            end
        end else if (req && accept) begin
            n.waitrequest = 1'b0;
            n.readdata = read ? readWord(address, r, busPower) : uft_pkg::UFT_RDATA_RST;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            r.pins <= uft_pkg::UFT_PINS_RST;
            r.txEnable <= 1'b0;
            r.holdValid <= 1'b0;
            r.holdSym <= 2'h0;
            r.txActive <= 1'b0;
            r.phase <= uft_pkg::UFT_PHASE_RST;
            r.sync1 <= uft_pkg::UFT_SYNC_RST;
            r.sync2 <= uft_pkg::UFT_SYNC_RST;
            r.sync3 <= uft_pkg::UFT_SYNC_RST;
            r.filt <= uft_pkg::UFT_SYNC_RST;
            r.rxSym <= 2'h0;
            r.rxValid <= 1'b0;
            r.rxCount <= uft_pkg::UFT_CNT_RST;
            r.txCount <= uft_pkg::UFT_CNT_RST;
            r.waitrequest <= 1'b1;
            r.readdata <= uft_pkg::UFT_RDATA_RST;
        end else if (ce) begin
            r <= n;
        end
    end

    assign readdata = r.readdata;
    assign waitrequest = r.waitrequest;
    assign pinOut = r.pins;

endmodule // uft_host_ctrl

// >>> uft_host_ctrl_checker.sv
// port assertions for the transceiver controller
module uft_host_ctrl_checker (
    input wire logic clk, // clock
    input wire logic rst, // reset
    input wire logic ce, // enable
    input wire logic [3:0] address, // address
    input wire logic read, // read
    input wire logic write, // write
    input wire logic [31:0] writedata, // wdata
    input wire logic [31:0] readdata, // rdata
    input wire logic waitrequest, // wait
    input wire uft_pkg::uft_pin_in_s pinIn, // pins in
    input wire uft_pkg::uft_pin_out_s pinOut // pins out
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic ctrlDone;
    assign ctrlDone = write && !waitrequest && address == uft_pkg::UFT_CTRL_OFS;
    AST_OE_PAIR: assert property (pinOut.datOe == !pinOut.oeN && pinOut.se0Oe == !pinOut.oeN)
        else $error("enables differ from direction");
    AST_WAIT_ONE: assert property (!waitrequest && ce |=> waitrequest)
        else $error("wait low too long");
    AST_SUSPEND: assert property (ctrlDone |=> pinOut.lowPowerRequest == $past(writedata[0]))
        else $error("suspend request wrong");
    AST_ATTACH: assert property (ctrlDone |=> pinOut.pullupConnect == $past(writedata[1]))
        else $error("pull-up attach wrong");
    AST_NO_POWER: assert property (!pinIn.busPowerDetect [*8] |-> pinOut.oeN)
        else $error("transmitting without bus power");
    AST_BIT_TIME: assert property ($fell(pinOut.oeN) |-> (!pinOut.oeN || !pinIn.busPowerDetect) [*3])
        else $error("symbol shorter than a bit time");
    AST_SYM_HOLD: assert property ($changed(pinOut.datOut) && !pinOut.oeN
        |=> ($stable(pinOut.datOut) || pinOut.oeN) [*2])
        else $error("data changed inside a bit time");
    AST_TXSYM_RD: assert property (read && !waitrequest && address == uft_pkg::UFT_TXSYM_OFS
        |-> readdata == 32'h0)
        else $error("symbol register read not zero");
    COV_TX: cover property ($fell(pinOut.oeN));
    COV_CTRL: cover property (ctrlDone);
    COV_SUSPEND_TX: cover property (pinOut.lowPowerRequest && !pinOut.oeN);
endmodule // uft_host_ctrl_checker

bind uft_host_ctrl uft_host_ctrl_checker u_chk (.clk(clk), .rst(rst), .ce(ce), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .pinIn(pinIn), .pinOut(pinOut));

// >>> uft_pkg.sv
// shared constants and carrier types for the usb full-speed transceiver controller
package uft_pkg;

    // register byte offsets on the avalon slave
    localparam logic [3:0] UFT_CTRL_OFS = 4'h0;
    localparam logic [3:0] UFT_STATUS_OFS = 4'h4;
    localparam logic [3:0] UFT_TXSYM_OFS = 4'h8;
    localparam logic [3:0] UFT_RXLINE_OFS = 4'hc;
    localparam logic [3:0] UFT_TXCNT_OFS = 4'h0;

    // control register fields
    localparam int UFT_CTRL_LPR_BIT = 0;
    localparam int UFT_CTRL_CONN_BIT = 1;
    localparam int UFT_CTRL_TXEN_BIT = 2;

    // status register fields
    localparam int UFT_ST_BPD_BIT = 0;
    localparam int UFT_ST_BUSY_BIT = 1;
    localparam int UFT_ST_FULL_BIT = 2;
    localparam int UFT_ST_RXOK_BIT = 3;
    localparam int UFT_ST_DIR_BIT = 4;

    // line symbol fields in TXSYM and RXLINE
    localparam int UFT_SYM_DAT_BIT = 0;
    localparam int UFT_SYM_SE0_BIT = 1;
    localparam int UFT_RX_VALID_BIT = 2;
    localparam int UFT_RXCNT_LSB = 16;

    // bit timing: 12 Mbit/s from a 40 MHz clock by a fractional accumulator
    localparam longint UFT_CLK_HZ = 40000000;
    localparam longint UFT_BIT_HZ = 12000000;
    localparam longint UFT_GCD_HZ = 4000000;
    localparam logic [3:0] UFT_PHASE_STEP = 4'(UFT_BIT_HZ / UFT_GCD_HZ);
    localparam logic [3:0] UFT_PHASE_MOD = 4'(UFT_CLK_HZ / UFT_GCD_HZ);

    // reset values
    localparam logic [31:0] UFT_RDATA_RST = 32'h0000_0000;
    localparam logic [15:0] UFT_CNT_RST = 16'h0000;
    localparam logic [2:0] UFT_SYNC_RST = 3'h0;
    localparam logic [3:0] UFT_PHASE_RST = 4'h0;

    // pins toward the transceiver, all registered
    typedef struct packed {
        logic oeN;             // direction control, low = controller transmits
        logic datOut;
        logic datOe;
        logic se0Out;
        logic se0Oe;
        logic lowPowerRequest;
        logic pullupConnect;
    } uft_pin_out_s;

    // pins from the transceiver
    typedef struct packed {
        logic busPowerDetect;
        logic se0In;
        logic datIn;
    } uft_pin_in_s;

    // whole controller state
    typedef struct packed {
        uft_pin_out_s pins;
        logic txEnable;
        logic holdValid;
        logic [1:0] holdSym;
        logic txActive;
        logic [3:0] phase;
        logic [2:0] sync1;
        logic [2:0] sync2;
        logic [2:0] sync3;
        logic [2:0] filt;
        logic [1:0] rxSym;
        logic rxValid;
        logic [15:0] rxCount;
        logic [15:0] txCount;
        logic waitrequest;
        logic [31:0] readdata;
    } uft_state_s;

    localparam uft_pin_out_s UFT_PINS_RST = '{
        oeN: 1'b1, datOut: 1'b0, datOe: 1'b0, se0Out: 1'b0, se0Oe: 1'b0,
        lowPowerRequest: 1'b0, pullupConnect: 1'b0};

endpackage

// >>> uft_xcvr_model.sv
// behavioural model of the three-wire usb transceiver
module uft_xcvr_model (
    input wire uft_pkg::uft_pin_out_s pinOut, // controller pins
    input wire logic vbus, // bus supply present
    input wire logic hostDp, // host positive line
    input wire logic hostDm, // host negative line
    output uft_pkg::uft_pin_in_s pinIn, // pins to controller
    output logic dp, // resolved positive line
    output logic dm // resolved negative line
);
    logic tx;
    logic lastDat = 1'b0;
    assign tx = vbus && !pinOut.oeN;
    // suspend does not gate the driver, so wake-up can be sent
    assign dp = tx ? !pinOut.se0Out && pinOut.datOut : hostDp;
    assign dm = tx ? !pinOut.se0Out && !pinOut.datOut : hostDm;
    always @(dp, dm) if (dp != dm) lastDat = dp;
    // floating or undefined pins show the inverse of the last value
    assign pinIn = '{busPowerDetect: vbus,
        se0In: !vbus ? !lastDat : tx ? pinOut.se0Out : !dp && !dm,
        datIn: tx ? pinOut.datOut
            : (!vbus || pinOut.lowPowerRequest || (dp && dm)) ? !lastDat : lastDat};
endmodule // uft_xcvr_model
